// file: sds_pkg.sv
// shared constants, command codes and helpers for the stack data storage block
package sds_pkg;

   // ----------------------------------------------------------------
   // number format and memory map
   // ----------------------------------------------------------------
   localparam int          DW          = 32;       // signed fixed-point value width
   localparam int          FRAC_W      = 8;        // fraction bits of a value
   localparam int          AW          = 13;       // word address width of the memory
   localparam logic [12:0] CONST_BASE  = 13'h0000; // constant registers
   localparam logic [12:0] OPW_BASE    = 13'h0400; // operational waveform
   localparam logic [12:0] STORE_BASE  = 13'h0800; // waveform memory slots

   // ----------------------------------------------------------------
   // limits and reset values
   // ----------------------------------------------------------------
   localparam int          CONST_STD_MAX = 49;
   localparam int          CONST_EXT_MAX = 99;
   localparam int          PPW_MIN_LOG   = 7;      // 128 points
   localparam int          PPW_128       = 128;
   localparam int          PPW_256       = 256;
   localparam int          PPW_512       = 512;
   localparam int          PPW_1024      = 1024;
   localparam logic [1:0]  PPW_RST_CODE  = 2'h3;   // 1024 points after reset
   localparam int          STK_DEPTH     = 4;

   // ----------------------------------------------------------------
   // commands
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_PUSH_NUM     = 4'h0,
      OP_RET_CONST    = 4'h1,
      OP_STORE_CONST  = 4'h2,
      OP_READ_PT      = 4'h3,
      OP_WRITE_PT     = 4'h4,
      OP_QUERY_PPW    = 4'h5,
      OP_SET_PPW      = 4'h6,
      OP_RECALL_WFM   = 4'h7,
      OP_COPY_WFM     = 4'h8
   } sds_op_t;

   // nearest integer of a fixed-point value, halves away from minus infinity
   function automatic logic signed [DW-1:0] sds_round(input logic signed [DW-1:0] v);
      logic signed [DW:0] s;
      s = {v[DW-1], v} + (DW+1)'(1 << (FRAC_W - 1));
      return DW'($signed(s[DW:FRAC_W]));
   endfunction

   // integer back to the fixed-point format
   function automatic logic signed [DW-1:0] sds_to_fix(input logic signed [DW-1:0] i);
      return DW'(i <<< FRAC_W);
   endfunction

endpackage

// file: sds_mem.sv
// simple dual-port word memory with registered read data
`timescale 1ns/100ps
module sds_mem #(
   parameter int DW = 33,
   parameter int AW = 13
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem [1 << AW];

   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_data <= '0;
      end
      else if (rd_en)
      begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// file: sds_cmd.sv
// data storage command interpreter of a stack-based waveform calculator
`timescale 1ns/100ps
module sds_cmd import sds_pkg::*; #(
   parameter int WFM_PTS  = 4096,
   parameter int VERT_LIM = 4
) (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire logic [3:0]           cmd_op,
   input  wire logic signed [DW-1:0] cmd_num,
   input  wire logic                 extended_memory_option,
   input  wire logic signed [DW-1:0] vert_scale,
   output logic                      cmd_done,
   output logic                      cmd_err,
   output logic                      err_flag,
   output logic                      clear_data_cmd,
   output logic signed [DW-1:0]      x_val,
   output logic signed [DW-1:0]      y_val,
   output logic signed [DW-1:0]      z_val,
   output logic signed [DW-1:0]      t_val,
   output logic                      x_tag,
   output logic                      y_tag,
   output logic                      z_tag,
   output logic                      t_tag,
   output logic [10:0]               ppw_value
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CP_RD, S_CP_WR} sds_state_t;

   sds_state_t           state_r, state_nxt;
   logic signed [DW-1:0] val_r [STK_DEPTH];
   logic signed [DW-1:0] val_nxt [STK_DEPTH];
   logic [STK_DEPTH-1:0] tag_r, tag_nxt;
   logic [1:0]           ppw_code_r, ppw_code_nxt;
   logic                 recall_r, recall_nxt;
   logic signed [DW-1:0] slot_r, slot_nxt;
   logic [10:0]          cnt_r, cnt_nxt;
   logic                 done_r, done_nxt;
   logic                 err_r, err_nxt;
   logic                 eflag_r, eflag_nxt;
   logic                 clr_r, clr_nxt;

   // ----------------------------------------------------------------
   // operand decode
   // ----------------------------------------------------------------
   wire logic signed [DW-1:0] x_idx      = sds_round(val_r[0]);
   wire logic signed [DW-1:0] y_idx      = sds_round(val_r[1]);
   wire logic                 x_const    = ~tag_r[0];
   wire logic                 y_const    = ~tag_r[1];
   wire logic signed [DW-1:0] const_max  = extended_memory_option ? CONST_EXT_MAX : CONST_STD_MAX;
   wire logic [3:0]           ppw_log    = 4'(PPW_MIN_LOG) + {2'h0, ppw_code_r};
   wire logic [10:0]          ppw        = 11'(PPW_128) << ppw_code_r;
   wire logic signed [DW-1:0] ppw_s      = DW'(ppw);
   wire logic signed [DW-1:0] nwfm       = DW'(WFM_PTS) >>> ppw_log;
   wire logic                 const_ok   = x_const && x_idx >= 0 && x_idx <= const_max;
   wire logic                 pt_ok      = x_const && x_idx >= 0 && x_idx < ppw_s;
   wire logic                 x_wfm_ok   = x_const && x_idx >= 0 && x_idx < nwfm;
   wire logic                 y_wfm_ok   = tag_r[1] && y_idx >= 0 && y_idx < nwfm;
   wire logic [DW-1:0]        y_mag      = val_r[1][DW-1] ? DW'(-val_r[1]) : val_r[1];
   wire logic [DW-1:0]        s_mag      = vert_scale[DW-1] ? DW'(-vert_scale) : vert_scale;
   wire logic [2*DW-1:0]      y_lim      = (2*DW)'(s_mag) * (2*DW)'(VERT_LIM);
   wire logic                 y_range_ok = y_const && (2*DW)'(y_mag) <= y_lim;

   wire logic x_is_128  = x_idx == PPW_128;
   wire logic x_is_256  = x_idx == PPW_256;
   wire logic x_is_512  = x_idx == PPW_512;
   wire logic x_is_1024 = x_idx == PPW_1024;
   wire logic ppw_ok    = x_const && (x_is_128 || x_is_256 || x_is_512 || x_is_1024);
   wire logic [1:0] new_code = x_is_1024 ? 2'h3 : x_is_512 ? 2'h2 : x_is_256 ? 2'h1 : 2'h0;

   wire sds_op_t op = sds_op_t'(cmd_op);
   wire logic    accept = cmd_valid && cmd_ready;

   logic op_ok;
   always_comb
   begin
      unique case (op)
         OP_PUSH_NUM:    op_ok = 1'b1;
         OP_RET_CONST:   op_ok = const_ok;
         OP_STORE_CONST: op_ok = const_ok;
         OP_READ_PT:     op_ok = pt_ok;
         OP_WRITE_PT:    op_ok = pt_ok && y_range_ok;
         OP_QUERY_PPW:   op_ok = 1'b1;
         OP_SET_PPW:     op_ok = ppw_ok;
         OP_RECALL_WFM:  op_ok = x_wfm_ok;
         OP_COPY_WFM:    op_ok = x_wfm_ok && y_wfm_ok;
         default:        op_ok = 1'b0;
      endcase
   end

   wire logic go = accept && op_ok;

   // ----------------------------------------------------------------
   // memory addressing
   // ----------------------------------------------------------------
   function automatic logic [AW-1:0] slot_addr(input logic signed [DW-1:0] slot,
                                               input logic [10:0] pt,
                                               input logic [3:0] lg);
      logic [DW-1:0] a;
      a = DW'(STORE_BASE) + (DW'(slot) << lg) + DW'(pt);
      return a[AW-1:0];
   endfunction

   wire logic [AW-1:0] cidx_addr = CONST_BASE + x_idx[AW-1:0];
   wire logic [AW-1:0] pidx_addr = OPW_BASE + x_idx[AW-1:0];
   wire logic [AW-1:0] opw_addr  = OPW_BASE + {2'h0, cnt_r};
   wire logic [AW-1:0] sto_addr  = slot_addr(slot_r, cnt_r, ppw_log);
   wire logic [AW-1:0] cp_src    = recall_r ? sto_addr : opw_addr;
   wire logic [AW-1:0] cp_dst    = recall_r ? opw_addr : sto_addr;

   wire logic          in_cp_rd  = state_r == S_CP_RD;
   wire logic          in_cp_wr  = state_r == S_CP_WR;
   wire logic          rd_en     = in_cp_rd || (go && (op == OP_RET_CONST || op == OP_READ_PT));
   wire logic [AW-1:0] rd_addr   = in_cp_rd ? cp_src : (op == OP_READ_PT ? pidx_addr : cidx_addr);
   wire logic          wr_direct = go && (op == OP_STORE_CONST || op == OP_WRITE_PT);
   wire logic          wr_en     = wr_direct || in_cp_wr;
   wire logic [AW-1:0] wr_addr   = in_cp_wr ? cp_dst : (op == OP_WRITE_PT ? pidx_addr : cidx_addr);
   wire logic [DW:0]   y_word    = {op == OP_WRITE_PT ? 1'b0 : tag_r[1], val_r[1]};
   logic [DW:0]        rd_data;
   wire logic [DW:0]   wr_data   = in_cp_wr ? rd_data : y_word;
   wire logic          last_pt   = cnt_r == ppw - 11'h001;

   sds_mem #(
      .DW (DW + 1),
      .AW (AW)
   ) u_mem (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ----------------------------------------------------------------
   // next state and stack
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt    = state_r;
      val_nxt      = val_r;
      tag_nxt      = tag_r;
      ppw_code_nxt = ppw_code_r;
      recall_nxt   = recall_r;
      slot_nxt     = slot_r;
      cnt_nxt      = cnt_r;
      done_nxt     = 1'b0;
      err_nxt      = 1'b0;
      eflag_nxt    = eflag_r;
      clr_nxt      = 1'b0;
      unique case (state_r)
         S_IDLE:
         begin
            if (accept && !op_ok)
            begin
               err_nxt   = 1'b1;
               eflag_nxt = 1'b1;
            end
            else if (go)
            begin
               eflag_nxt = 1'b0;
               unique case (op)
                  OP_PUSH_NUM, OP_QUERY_PPW:
                  begin
                     for (int i = STK_DEPTH - 1; i > 0; i--)
                     begin
                        val_nxt[i] = val_r[i-1];
                        tag_nxt[i] = tag_r[i-1];
                     end
                     val_nxt[0] = (op == OP_QUERY_PPW) ? sds_to_fix(ppw_s) : cmd_num;
                     tag_nxt[0] = 1'b0;
                     done_nxt   = 1'b1;
                  end
                  OP_RET_CONST, OP_READ_PT:
                  begin
                     state_nxt = S_WAIT;
                  end
                  OP_STORE_CONST, OP_WRITE_PT:
                  begin
                     for (int i = 0; i < STK_DEPTH - 1; i++)
                     begin
                        val_nxt[i] = val_r[i+1];
                        tag_nxt[i] = tag_r[i+1];
                     end
                     if (op == OP_STORE_CONST && tag_r[1])
                     begin
                        val_nxt[0] = sds_to_fix(y_idx);
                        tag_nxt[0] = 1'b0;
                     end
                     done_nxt = 1'b1;
                  end
                  OP_SET_PPW:
                  begin
                     ppw_code_nxt = new_code;
                     for (int i = 0; i < STK_DEPTH; i++)
                     begin
                        val_nxt[i] = '0;
                     end
                     tag_nxt  = '0;
                     clr_nxt  = 1'b1;
                     done_nxt = 1'b1;
                  end
                  OP_RECALL_WFM, OP_COPY_WFM:
                  begin
                     recall_nxt = op == OP_RECALL_WFM;
                     slot_nxt   = x_idx;
                     cnt_nxt    = '0;
                     state_nxt  = S_CP_RD;
                  end
                  default:
                  begin
                     done_nxt = 1'b1;
                  end
               endcase
            end
         end
         S_WAIT:
         begin
            val_nxt[0] = rd_data[DW-1:0];
            tag_nxt[0] = rd_data[DW];
            done_nxt   = 1'b1;
            state_nxt  = S_IDLE;
         end
         S_CP_RD:
         begin
            state_nxt = S_CP_WR;
         end
         S_CP_WR:
         begin
            cnt_nxt   = cnt_r + 11'h001;
            state_nxt = S_CP_RD;
            if (last_pt)
            begin
               state_nxt  = S_IDLE;
               done_nxt   = 1'b1;
               val_nxt[0] = sds_to_fix(slot_r);
               tag_nxt[0] = 1'b1;
               if (!recall_r)
               begin
                  val_nxt[1] = val_r[2];
                  tag_nxt[1] = tag_r[2];
                  val_nxt[2] = val_r[3];
                  tag_nxt[2] = tag_r[3];
               end
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r    <= S_IDLE;
         for (int i = 0; i < STK_DEPTH; i++)
         begin
            val_r[i] <= '0;
         end
         tag_r      <= '0;
         ppw_code_r <= PPW_RST_CODE;
         recall_r   <= 1'b0;
         slot_r     <= '0;
         cnt_r      <= '0;
         done_r     <= 1'b0;
         err_r      <= 1'b0;
         eflag_r    <= 1'b0;
         clr_r      <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         val_r      <= val_nxt;
         tag_r      <= tag_nxt;
         ppw_code_r <= ppw_code_nxt;
         recall_r   <= recall_nxt;
         slot_r     <= slot_nxt;
         cnt_r      <= cnt_nxt;
         done_r     <= done_nxt;
         err_r      <= err_nxt;
         eflag_r    <= eflag_nxt;
         clr_r      <= clr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_ready      = state_r == S_IDLE;
   assign cmd_done       = done_r;
   assign cmd_err        = err_r;
   assign err_flag       = eflag_r;
   assign clear_data_cmd = clr_r;
   assign x_val          = val_r[0];
   assign y_val          = val_r[1];
   assign z_val          = val_r[2];
   assign t_val          = val_r[3];
   assign x_tag          = tag_r[0];
   assign y_tag          = tag_r[1];
   assign z_tag          = tag_r[2];
   assign t_tag          = tag_r[3];
   assign ppw_value      = ppw;

endmodule

// file: sds_cmd_chk.sv
// concurrent checks on the ports of the data storage command interpreter
`timescale 1ns/100ps
module sds_cmd_chk import sds_pkg::*; (
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire logic                 cmd_valid,
   input wire logic                 cmd_ready,
   input wire logic [3:0]           cmd_op,
   input wire logic signed [DW-1:0] cmd_num,
   input wire logic                 cmd_done,
   input wire logic                 cmd_err,
   input wire logic                 err_flag,
   input wire logic                 clear_data_cmd,
   input wire logic signed [DW-1:0] x_val,
   input wire logic signed [DW-1:0] y_val,
   input wire logic signed [DW-1:0] z_val,
   input wire logic signed [DW-1:0] t_val,
   input wire logic                 x_tag,
   input wire logic [10:0]          ppw_value
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // command sequences
   // ----------------------------------------------------------------
   sequence take_any;
      cmd_valid && cmd_ready;
   endsequence
   sequence take_slow;
      take_any ##0 (cmd_op == 4'h1 || cmd_op == 4'h3);
   endsequence
   sequence take_fast;
      take_any ##0 (cmd_op == 4'h0 || cmd_op == 4'h2 || (cmd_op >= 4'h4 && cmd_op <= 4'h6));
   endsequence
   sequence mem_answer;
      !cmd_done && !cmd_err ##1 cmd_done;
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_slow_answer: assert property (take_slow |=> (cmd_err or mem_answer))
      else $error("memory read command answer not in two cycles");
   a_fast_answer: assert property (take_fast |=> (cmd_done != cmd_err))
      else $error("single cycle command gave no single answer");
   a_bad_op: assert property (take_any ##0 cmd_op > 4'h8 |=> cmd_err && err_flag)
      else $error("unknown command not refused");
   a_err_flag_set: assert property (cmd_err |-> err_flag)
      else $error("refusal without error flag");
   a_err_no_change: assert property (cmd_err |-> $stable(x_val) && $stable(y_val) && $stable(z_val)
                                     && $stable(t_val) && $stable(ppw_value))
      else $error("refused command changed the stack");
   a_done_excl: assert property (!(cmd_done && cmd_err))
      else $error("done and error together");
   a_clear_stack: assert property (clear_data_cmd |-> cmd_done && x_val == '0 && y_val == '0
                                   && z_val == '0 && t_val == '0 && !x_tag)
      else $error("clear data without cleared stack");
   a_ppw_legal: assert property (ppw_value inside {11'h080, 11'h100, 11'h200, 11'h400})
      else $error("points per waveform outside the four sizes");
   a_ppw_change: assert property ($changed(ppw_value) |-> clear_data_cmd)
      else $error("size changed without clear data");
   a_query_ppw: assert property (take_any ##0 cmd_op == 4'h5
                                 |=> cmd_done && x_val == (DW'(ppw_value) <<< FRAC_W) && !x_tag)
      else $error("size query pushed a wrong value");
   a_push_const: assert property (take_any ##0 cmd_op == 4'h0
                                  |=> x_val == $past(cmd_num) && !x_tag && y_val == $past(x_val))
      else $error("pushed number wrong or not tagged constant");
endmodule

bind sds_cmd sds_cmd_chk i_sds_cmd_chk (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_num(cmd_num), .cmd_done(cmd_done), .cmd_err(cmd_err),
   .err_flag(err_flag), .clear_data_cmd(clear_data_cmd), .x_val(x_val), .y_val(y_val), .z_val(z_val),
   .t_val(t_val), .x_tag(x_tag), .ppw_value(ppw_value));

// file: sds_kbd.sv
// keyboard model that issues one stack command at a time
`timescale 1ns/100ps
module sds_kbd import sds_pkg::*; (
   input  wire logic            ref_clk,
   input  wire logic            cmd_ready,
   output logic                 cmd_valid,
   output logic [3:0]           cmd_op,
   output logic signed [DW-1:0] cmd_num
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_op    = 4'h0;
      cmd_num   = '0;
   end

   // request held through the taking edge, then qualifiers inverted
   task automatic send(input logic [3:0] op, input logic signed [DW-1:0] num, input int gap);
      repeat (gap) @(negedge ref_clk);
      @(negedge ref_clk);
      cmd_op    = op;
      cmd_num   = num;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1)
         @(negedge ref_clk);
      @(posedge ref_clk);
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_op    = ~op;
      cmd_num   = ~num;
   endtask
endmodule

// file: tb.sv
// self-checking bench for the data storage command interpreter
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module tb import sds_pkg::*;;
   logic                 ref_clk, nrst, extended_memory_option, cmd_valid, cmd_ready;
   logic                 cmd_done, cmd_err, err_flag, clear_data_cmd, x_tag, y_tag, z_tag, t_tag;
   logic [3:0]           cmd_op;
   logic signed [DW-1:0] cmd_num, vert_scale, x_val, y_val, z_val, t_val;
   logic [10:0]          ppw_value;
   int                   num_errors, comparisons, kbd_gap;
   int                   cycles = 0;

   sds_kbd i_sds_kbd (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
                      .cmd_num(cmd_num));
   sds_cmd i_sds_cmd (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_num(cmd_num), .extended_memory_option(extended_memory_option),
      .vert_scale(vert_scale), .cmd_done(cmd_done), .cmd_err(cmd_err), .err_flag(err_flag),
      .clear_data_cmd(clear_data_cmd), .x_val(x_val), .y_val(y_val), .z_val(z_val), .t_val(t_val),
      .x_tag(x_tag), .y_tag(y_tag), .z_tag(z_tag), .t_tag(t_tag), .ppw_value(ppw_value));

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic signed [DW-1:0] fx(input int i);
      return DW'(i) <<< FRAC_W;
   endfunction

   task automatic run(input logic [3:0] op, input logic signed [DW-1:0] num, input logic exp_err);
      int n;
      i_sds_kbd.send(op, num, kbd_gap);
      n = 0;
      while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 3000)
      begin
         @(negedge ref_clk);
         n++;
      end
      `CHK(cmd_err, exp_err)
      `CHK(cmd_done, !exp_err)
   endtask

   task automatic push(input logic signed [DW-1:0] num);
      run(OP_PUSH_NUM, num, 1'b0);
   endtask

   task automatic end_sim();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      `CHK(ppw_value, 11'h400)
      `CHK(x_val, fx(0))
      `CHK(x_tag, 1'b0)
      `CHK(cmd_ready, 1'b1)
   endtask

   task automatic t_const();
      push(fx(7));
      push(fx(49));
      run(OP_STORE_CONST, '0, 1'b0);
      `CHK(x_val, fx(7))
      push(fx(49) - 32'sh80);
      run(OP_RET_CONST, '0, 1'b0);
      `CHK(x_val, fx(7))
      push(fx(49) + 32'sh80);
      run(OP_RET_CONST, '0, 1'b1);
      `CHK(x_val, fx(49) + 32'sh80)
      `CHK(err_flag, 1'b1)
      extended_memory_option = 1'b1;
      push(fx(99));
      run(OP_STORE_CONST, '0, 1'b0);
      push(fx(99));
      run(OP_RET_CONST, '0, 1'b0);
      `CHK(x_val, fx(49) + 32'sh80)
      push(fx(99) + 32'sh80);
      run(OP_RET_CONST, '0, 1'b1);
      extended_memory_option = 1'b0;
      push(fx(99));
      run(OP_STORE_CONST, '0, 1'b1);
   endtask

   task automatic t_point();
      kbd_gap = 2;
      push(fx(4));
      push(fx(1023));
      run(OP_WRITE_PT, '0, 1'b0);
      `CHK(x_val, fx(4))
      push(fx(1023));
      run(OP_READ_PT, '0, 1'b0);
      `CHK(x_val, fx(4))
      push(fx(1024));
      run(OP_READ_PT, '0, 1'b1);
      run(OP_WRITE_PT, '0, 1'b1);
      push(fx(-5));
      push(fx(0));
      run(OP_WRITE_PT, '0, 1'b1);
      vert_scale = fx(2);
      run(OP_WRITE_PT, '0, 1'b0);
      push(fx(0));
      run(OP_READ_PT, '0, 1'b0);
      `CHK(x_val, fx(-5))
      kbd_gap = 0;
   endtask

   task automatic t_ppw();
      int sz[4] = '{512, 256, 1024, 128};
      run(OP_QUERY_PPW, '0, 1'b0);
      `CHK(x_val, fx(1024))
      push(fx(100));
      run(OP_SET_PPW, '0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         push(fx(sz[i]) - 32'sh40);
         run(OP_SET_PPW, '0, 1'b0);
         `CHK(clear_data_cmd, 1'b1)
         `CHK({x_val, y_val, z_val, t_val}, 128'h0)
         `CHK(ppw_value, 11'(sz[i]))
         run(OP_QUERY_PPW, '0, 1'b0);
         `CHK(x_val, fx(sz[i]))
      end
   endtask

   task automatic t_wfm();
      push(fx(0));
      push(fx(3));
      run(OP_COPY_WFM, '0, 1'b1);
      push(fx(31));
      run(OP_RECALL_WFM, '0, 1'b0);
      `CHK(x_val, fx(31))
      `CHK(x_tag, 1'b1)
      push(fx(5));
      `CHK(y_tag, 1'b1)
      run(OP_COPY_WFM, '0, 1'b0);
      `CHK(x_val, fx(5))
      `CHK(y_val, fx(3))
      push(fx(32));
      run(OP_RECALL_WFM, '0, 1'b1);
      run(OP_COPY_WFM, '0, 1'b1);
      run(OP_STORE_CONST, '0, 1'b0);
      `CHK(x_val, fx(5))
      `CHK(x_tag, 1'b0)
      run(4'h9, '0, 1'b1);
      `CHK(err_flag, 1'b1)
      push(fx(1));
      `CHK(err_flag, 1'b0)
   endtask

   initial
   begin
      nrst = 1'b0;
      extended_memory_option = 1'b0;
      vert_scale = fx(1);
      num_errors = 0;
      comparisons = 0;
      kbd_gap = 0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      t_reset();
      t_const();
      t_point();
      t_ppw();
      t_wfm();
      end_sim();
   end
endmodule
